/* core/irq_pkg.sv */
package irq_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_PERIPH_IRQ_ENABLE  = 8'h04;
  localparam logic [7:0] ADDR_PERIPH_FLAG        = 8'h08;
  localparam logic [7:0] ADDR_PER_PIN_CHANGE_EN  = 8'h0C;
  localparam logic [7:0] ADDR_TIMER_COUNT        = 8'h10;

  // ---------------------------------------------------------------
  // Interrupt control field positions
  // ---------------------------------------------------------------
  localparam int BIT_GLOBAL_IRQ_ENABLE     = 7;
  localparam int BIT_PERIPH_GROUP_ENABLE   = 6;
  localparam int BIT_TIMER_OVF_IRQ_ENABLE  = 5;
  localparam int BIT_EXT_PIN_IRQ_ENABLE    = 4;
  localparam int BIT_PORT_CHANGE_IRQ_EN    = 3;
  localparam int BIT_TIMER_OVERFLOW_FLAG   = 2;
  localparam int BIT_EXT_PIN_FLAG          = 1;
  localparam int BIT_PORT_CHANGE_FLAG      = 0;

  // ---------------------------------------------------------------
  // Peripheral field positions
  // ---------------------------------------------------------------
  localparam int BIT_EEPROM_WRITE_DONE     = 7;
  localparam int BIT_CONVERTER_DONE        = 6;
  localparam int BIT_SERIAL_RX             = 5;
  localparam int BIT_COMPARATOR_TWO        = 4;
  localparam int BIT_COMPARATOR_ONE        = 3;
  localparam int BIT_OSC_FAIL              = 2;
  localparam int BIT_SERIAL_TX             = 1;
  localparam int BIT_TIMER_ONE_OVERFLOW    = 0;

  // ---------------------------------------------------------------
  // Reset values and widths
  // ---------------------------------------------------------------
  localparam logic [6:0] RESET_CONTROL_HIGH    = 7'h00;
  localparam logic [7:0] RESET_PERIPH_ENABLE   = 8'h00;
  localparam logic [7:0] RESET_PERIPH_FLAG     = 8'h00;
  localparam logic [5:0] RESET_PER_PIN_ENABLE  = 6'h00;
  localparam int         PORT_PINS             = 6;
  localparam int         SYNC_STAGES           = 3;

endpackage : irq_pkg

/* core/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pin side
  input  wire logic [WIDTH-1:0] pin,
  // Filtered level and change pulse
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] changed
);

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_three;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] next_level;
  logic             primed;

  // Zero width leaves nothing to filter
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync width must be positive");
  end

  // Level moves only when the last two stages agree
  assign agree      = ~(stage_two ^ stage_three);
  assign next_level = (agree & stage_three) | (~agree & level);

  always_ff @(posedge clk) begin
    stage_one   <= pin;
    stage_two   <= stage_one;
    stage_three <= stage_two;
    if (rst) begin
      level   <= '0;
      changed <= '0;
      primed  <= 1'b0;
    end else begin
      // First cycle after reset only learns the pin level
      primed  <= 1'b1;
      level   <= next_level;
      changed <= primed ? (next_level ^ level) : '0;
    end
  end

endmodule : pin_sync

/* core/sticky_flag.sv */
`timescale 1ns/1ns
module sticky_flag (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rst_value,
  // Events
  input  wire logic set,
  input  wire logic clear,
  input  wire logic load,
  input  wire logic load_value,
  // State
  output logic      flag
);

  logic next_flag;

  // Set beats clear so a coincident event is never lost
  assign next_flag = set ? 1'b1 : (clear ? 1'b0 : (load ? load_value : flag));

  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= rst_value;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : sticky_flag

/* core/core_interrupt_enable_flag_logic.sv */
// Summary of operation
// - Global enable passes unmasked interrupts to the core; cleared blocks all.
// - Peripheral group enable passes unmasked peripheral interrupts; cleared blocks them.
// - Timer overflow enable gates the timer overflow interrupt.
// - External pin enable gates the external edge interrupt.
// - Port change enable gates the port change interrupt.
// - Port change also needs the per-pin change enable for that pin.
// - Timer overflow flag sets on rollover, stays until software writes zero.
// - Timer count keeps its value across reset; software initialises it.
// - External pin flag sets on the pin event, stays until software clears.
// - Port change flag sets when any of six pins with its per-pin change enable set changes, sticky.
// - Flags set on their condition regardless of any enable, except port change, which needs the per-pin change enable.
// - Peripheral enable register holds eight source enables, one bit each.
// - No peripheral interrupt reaches the core without the group enable.
// - Reset clears control bits seven to one and all peripheral enables.
// - Peripheral flags mirror enable positions; oscillator fail is software cleared.
// - Receive flag clears on data read, transmit flag on data write.
`timescale 1ns/1ns
module core_interrupt_enable_flag_logic (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // External pins
  input  wire logic        EXTERNAL_IRQ_PIN,
  input  wire logic        EXT_EDGE_RISING,
  input  wire logic [5:0]  FIRST_GPIO_PORT,
  // Timer and peripheral events, one-cycle pulses on CLOCK
  input  wire logic        TIMER_TICK,
  input  wire logic [7:0]  PERIPH_EVENT,
  input  wire logic        RX_DATA_READ,
  input  wire logic        TX_DATA_WRITE,
  // Request to the core
  output logic             IRQ_REQUEST
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire access      = PSEL & PENABLE;
  wire wr_access   = access & PWRITE & PSTRB[0];
  wire sel_control = (PADDR == irq_pkg::ADDR_INTERRUPT_CONTROL);
  wire sel_penable = (PADDR == irq_pkg::ADDR_PERIPH_IRQ_ENABLE);
  wire sel_pflag   = (PADDR == irq_pkg::ADDR_PERIPH_FLAG);
  wire sel_pinen   = (PADDR == irq_pkg::ADDR_PER_PIN_CHANGE_EN);
  wire sel_timer   = (PADDR == irq_pkg::ADDR_TIMER_COUNT);
  wire mapped      = sel_control | sel_penable | sel_pflag | sel_pinen | sel_timer;
  wire wr_control  = wr_access & sel_control;
  wire wr_penable  = wr_access & sel_penable;
  wire wr_pflag    = wr_access & sel_pflag;
  wire wr_pinen    = wr_access & sel_pinen;
  wire wr_timer    = wr_access & sel_timer;
  wire [7:0] wbyte = PWDATA[7:0];

  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~mapped;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [6:2] control_high;
  logic [7:0] periph_enable;
  logic [5:0] per_pin_change_enable;
  logic [7:0] timer_count_register;
  logic [7:0] periph_flag;
  logic       port_change_flag;
  logic       timer_overflow_flag;
  logic       ext_pin_flag;
  logic [7:0] control;

  wire global_irq_enable         = control_high[irq_pkg::BIT_GLOBAL_IRQ_ENABLE - 1];
  wire periph_group_enable       = control_high[irq_pkg::BIT_PERIPH_GROUP_ENABLE - 1];
  wire timer_overflow_irq_enable = control_high[irq_pkg::BIT_TIMER_OVF_IRQ_ENABLE - 1];
  wire ext_pin_irq_enable        = control_high[irq_pkg::BIT_EXT_PIN_IRQ_ENABLE - 1];
  wire port_change_irq_enable    = control_high[irq_pkg::BIT_PORT_CHANGE_IRQ_EN - 1];

  assign control = {control_high[6:2], timer_overflow_flag, ext_pin_flag, port_change_flag};

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      control_high[6:2]     <= irq_pkg::RESET_CONTROL_HIGH[6:2];
      periph_enable         <= irq_pkg::RESET_PERIPH_ENABLE;
      per_pin_change_enable <= irq_pkg::RESET_PER_PIN_ENABLE;
    end else begin
      if (wr_control) begin
        control_high[6:2] <= wbyte[7:3];
      end
      if (wr_penable) begin
        periph_enable <= wbyte;
      end
      if (wr_pinen) begin
        per_pin_change_enable <= wbyte[5:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Timer count
  // ---------------------------------------------------------------
  wire timer_rollover = TIMER_TICK & (timer_count_register == 8'hFF);

  always_ff @(posedge CLOCK) begin
    if (wr_timer) begin
      timer_count_register <= wbyte;
    end else if (TIMER_TICK) begin
      timer_count_register <= timer_count_register + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Pin inputs
  // ---------------------------------------------------------------
  logic [6:0] pin_level;
  logic [6:0] pin_change;

  pin_sync #(.WIDTH(7)) u_pin_sync (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .pin     ({EXTERNAL_IRQ_PIN, FIRST_GPIO_PORT}),
    .level   (pin_level),
    .changed (pin_change)
  );

  wire ext_edge = pin_change[6] & (pin_level[6] == EXT_EDGE_RISING);
  wire port_change_event = |(pin_change[5:0] & per_pin_change_enable);

  // ---------------------------------------------------------------
  // Core flags
  // ---------------------------------------------------------------
  // sticky timer overflow flag
  sticky_flag u_timer_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (1'b0),
    .set        (timer_rollover),
    .clear      (1'b0),
    .load       (wr_control),
    .load_value (wbyte[irq_pkg::BIT_TIMER_OVERFLOW_FLAG]),
    .flag       (timer_overflow_flag)
  );

  sticky_flag u_ext_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (1'b0),
    .set        (ext_edge),
    .clear      (1'b0),
    .load       (wr_control),
    .load_value (wbyte[irq_pkg::BIT_EXT_PIN_FLAG]),
    .flag       (ext_pin_flag)
  );

  // sticky port change flag
  // Unknown at reset in silicon; held at zero here for defined state
  sticky_flag u_port_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (1'b0),
    .set        (port_change_event),
    .clear      (1'b0),
    .load       (wr_control),
    .load_value (wbyte[irq_pkg::BIT_PORT_CHANGE_FLAG]),
    .flag       (port_change_flag)
  );

  // ---------------------------------------------------------------
  // Peripheral flags
  // ---------------------------------------------------------------
  // flags at enable positions
  sticky_flag u_eeprom_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (irq_pkg::RESET_PERIPH_FLAG[irq_pkg::BIT_EEPROM_WRITE_DONE]),
    .set        (PERIPH_EVENT[irq_pkg::BIT_EEPROM_WRITE_DONE]),
    .clear      (1'b0),
    .load       (wr_pflag),
    .load_value (wbyte[irq_pkg::BIT_EEPROM_WRITE_DONE]),
    .flag       (periph_flag[irq_pkg::BIT_EEPROM_WRITE_DONE])
  );

  sticky_flag u_converter_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (irq_pkg::RESET_PERIPH_FLAG[irq_pkg::BIT_CONVERTER_DONE]),
    .set        (PERIPH_EVENT[irq_pkg::BIT_CONVERTER_DONE]),
    .clear      (1'b0),
    .load       (wr_pflag),
    .load_value (wbyte[irq_pkg::BIT_CONVERTER_DONE]),
    .flag       (periph_flag[irq_pkg::BIT_CONVERTER_DONE])
  );

  // receive flag clears on read
  // Not loadable, so software cannot drop unread data
  sticky_flag u_rx_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (irq_pkg::RESET_PERIPH_FLAG[irq_pkg::BIT_SERIAL_RX]),
    .set        (PERIPH_EVENT[irq_pkg::BIT_SERIAL_RX]),
    .clear      (RX_DATA_READ),
    .load       (1'b0),
    .load_value (1'b0),
    .flag       (periph_flag[irq_pkg::BIT_SERIAL_RX])
  );

  sticky_flag u_cmp_two_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (irq_pkg::RESET_PERIPH_FLAG[irq_pkg::BIT_COMPARATOR_TWO]),
    .set        (PERIPH_EVENT[irq_pkg::BIT_COMPARATOR_TWO]),
    .clear      (1'b0),
    .load       (wr_pflag),
    .load_value (wbyte[irq_pkg::BIT_COMPARATOR_TWO]),
    .flag       (periph_flag[irq_pkg::BIT_COMPARATOR_TWO])
  );

  sticky_flag u_cmp_one_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (irq_pkg::RESET_PERIPH_FLAG[irq_pkg::BIT_COMPARATOR_ONE]),
    .set        (PERIPH_EVENT[irq_pkg::BIT_COMPARATOR_ONE]),
    .clear      (1'b0),
    .load       (wr_pflag),
    .load_value (wbyte[irq_pkg::BIT_COMPARATOR_ONE]),
    .flag       (periph_flag[irq_pkg::BIT_COMPARATOR_ONE])
  );

  sticky_flag u_osc_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (irq_pkg::RESET_PERIPH_FLAG[irq_pkg::BIT_OSC_FAIL]),
    .set        (PERIPH_EVENT[irq_pkg::BIT_OSC_FAIL]),
    .clear      (1'b0),
    .load       (wr_pflag),
    .load_value (wbyte[irq_pkg::BIT_OSC_FAIL]),
    .flag       (periph_flag[irq_pkg::BIT_OSC_FAIL])
  );

  sticky_flag u_tx_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (irq_pkg::RESET_PERIPH_FLAG[irq_pkg::BIT_SERIAL_TX]),
    .set        (PERIPH_EVENT[irq_pkg::BIT_SERIAL_TX]),
    .clear      (TX_DATA_WRITE),
    .load       (1'b0),
    .load_value (1'b0),
    .flag       (periph_flag[irq_pkg::BIT_SERIAL_TX])
  );

  sticky_flag u_timer_one_flag (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .rst_value  (irq_pkg::RESET_PERIPH_FLAG[irq_pkg::BIT_TIMER_ONE_OVERFLOW]),
    .set        (PERIPH_EVENT[irq_pkg::BIT_TIMER_ONE_OVERFLOW]),
    .clear      (1'b0),
    .load       (wr_pflag),
    .load_value (wbyte[irq_pkg::BIT_TIMER_ONE_OVERFLOW]),
    .flag       (periph_flag[irq_pkg::BIT_TIMER_ONE_OVERFLOW])
  );

  // ---------------------------------------------------------------
  // Request combine
  // ---------------------------------------------------------------
  // flags above set without enable terms, except port change via per-pin change enables
  wire timer_pair = timer_overflow_irq_enable & timer_overflow_flag;
  wire ext_pair   = ext_pin_irq_enable & ext_pin_flag;
  wire port_pair  = port_change_irq_enable & port_change_flag;
  wire periph_req = periph_group_enable & |(periph_flag & periph_enable);
  wire next_irq   = global_irq_enable & (timer_pair | ext_pair | port_pair | periph_req);

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  wire [7:0] read_byte =
    sel_control ? control :
    sel_penable ? periph_enable :
    sel_pflag   ? periph_flag :
    sel_pinen   ? {2'b00, per_pin_change_enable} :
    sel_timer   ? timer_count_register : 8'h00;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      IRQ_REQUEST <= 1'b0;
      PRDATA      <= 32'h0000_0000;
    end else begin
      IRQ_REQUEST <= next_irq;
      // Read data is set up during the setup cycle, valid at access
      PRDATA      <= (PSEL & ~PENABLE & ~PWRITE) ? {24'h00_0000, read_byte} : PRDATA;
    end
  end

endmodule : core_interrupt_enable_flag_logic

/* test/irq_checker_properties.sv */
`timescale 1ns/1ns
module irq_checker (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  // Register bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Events and request
  input wire logic        RX_DATA_READ,
  input wire logic        TX_DATA_WRITE,
  input wire logic        IRQ_REQUEST
);
  wire logic mapped;
  wire logic wr;
  assign mapped = PADDR inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  assign wr     = PSEL && PENABLE && PWRITE && PSTRB[0];
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_access; PSEL && PENABLE; endsequence
  sequence s_ctl_wr; wr && PADDR == irq_pkg::ADDR_INTERRUPT_CONTROL; endsequence
  property p_reset_quiet; $past(SYS_RST) |-> !IRQ_REQUEST && PRDATA == 32'h0000_0000; endproperty
  property p_ready; s_access |-> PREADY; endproperty
  property p_slverr; s_access |-> PSLVERR == !mapped; endproperty
  property p_hole_zero; PSEL && !PENABLE && !PWRITE && !mapped |=> PRDATA == 32'h0000_0000;
  endproperty
  property p_upper_zero; PRDATA[31:8] == 24'h00_0000; endproperty
  property p_global_off; s_ctl_wr ##0 !PWDATA[7] |=> ##1 !IRQ_REQUEST; endproperty
  property p_group_off; s_ctl_wr ##0 PWDATA[6:3] == 4'h0 |=> ##1 !IRQ_REQUEST; endproperty
  // Flags only fall by software, so the request cannot drop on its own
  property p_fall_cause; $fell(IRQ_REQUEST) |-> $past(wr, 2) || $past(RX_DATA_READ, 2) ||
    $past(TX_DATA_WRITE, 2) || $past(SYS_RST, 1) || $past(SYS_RST, 2); endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet after reset");
  a_ready: assert property (p_ready) else $error("ready low in access");
  a_slverr: assert property (p_slverr) else $error("error flag wrong");
  a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_global_off: assert property (p_global_off) else $error("request with global off");
  a_group_off: assert property (p_group_off) else $error("request with groups off");
  a_fall_cause: assert property (p_fall_cause) else $error("request fell alone");
endmodule : irq_checker

bind core_interrupt_enable_flag_logic irq_checker irq_checker_i (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .RX_DATA_READ(RX_DATA_READ), .TX_DATA_WRITE(TX_DATA_WRITE),
  .IRQ_REQUEST(IRQ_REQUEST));

/* test/event_source.sv */
`timescale 1ns/1ns
module event_source (
  // Clock and command
  input wire logic       clk,
  input wire logic       fire,
  input wire logic [3:0] sel,
  // Pulses toward the block
  output logic     [7:0] periph_event = 8'h00,
  output logic           timer_tick = 1'b0,
  output logic           rx_read = 1'b0,
  output logic           tx_write = 1'b0
);
  // Registered so each pulse spans exactly one cycle
  always @(posedge clk) begin
    periph_event <= (fire && sel < 4'h8) ? 8'h01 << sel[2:0] : 8'h00;
    timer_tick   <= fire && sel == 4'h8;
    rx_read      <= fire && sel == 4'h9;
    tx_write     <= fire && sel == 4'hA;
  end
endmodule : event_source

/* test/tb_core_interrupt_enable_flag_logic.sv */
`timescale 1ns/1ns
module tb_core_interrupt_enable_flag_logic;
  localparam logic [7:0] ctl = irq_pkg::ADDR_INTERRUPT_CONTROL;
  localparam logic [7:0] pie = irq_pkg::ADDR_PERIPH_IRQ_ENABLE;
  localparam logic [7:0] pfl = irq_pkg::ADDR_PERIPH_FLAG;
  logic        CLOCK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00, q, t;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
  logic [3:0]  PSTRB = 4'hF, sel = 4'h0;
  logic        EXTERNAL_IRQ_PIN = 1'b0, EXT_EDGE_RISING = 1'b1, fire = 1'b0;
  logic [5:0]  FIRST_GPIO_PORT = 6'h00;
  logic        PREADY, PSLVERR, TIMER_TICK, RX_DATA_READ, TX_DATA_WRITE, IRQ_REQUEST;
  logic [7:0]  PERIPH_EVENT;
  logic        e;
  int          miscompares = 0, n_checks = 0, cycles = 0, p;

  core_interrupt_enable_flag_logic core_interrupt_enable_flag_logic_i (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EXTERNAL_IRQ_PIN(EXTERNAL_IRQ_PIN), .EXT_EDGE_RISING(EXT_EDGE_RISING),
    .FIRST_GPIO_PORT(FIRST_GPIO_PORT), .TIMER_TICK(TIMER_TICK), .PERIPH_EVENT(PERIPH_EVENT),
    .RX_DATA_READ(RX_DATA_READ), .TX_DATA_WRITE(TX_DATA_WRITE), .IRQ_REQUEST(IRQ_REQUEST));
  event_source event_source_i (.clk(CLOCK), .fire(fire), .sel(sel),
    .periph_event(PERIPH_EVENT), .timer_tick(TIMER_TICK), .rx_read(RX_DATA_READ),
    .tx_write(TX_DATA_WRITE));

  initial forever #50 CLOCK = ~CLOCK;

  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Run is about 540 cycles; a hang ends here
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h00_0000, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    q = PRDATA[7:0];
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    n_checks++;
    if (q !== exp) begin
      miscompares++;
      $display("MISMATCH %0t reg %h got %h exp %h", $time, a, q, exp);
    end
  endtask : chk_reg

  task automatic chk_err(input logic exp);
    n_checks++;
    if (e !== exp) begin
      miscompares++;
      $display("MISMATCH %0t error flag got %b exp %b", $time, e, exp);
    end
  endtask : chk_err

  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge CLOCK);
    #1;
    n_checks++;
    if (IRQ_REQUEST !== exp) begin
      miscompares++;
      $display("MISMATCH %0t request got %b exp %b", $time, IRQ_REQUEST, exp);
    end
  endtask : chk_irq

  task automatic pulse(input logic [3:0] s);
    @(posedge CLOCK);
    fire <= 1'b1;
    sel <= s;
    @(posedge CLOCK);
    fire <= 1'b0;
    repeat (2) @(posedge CLOCK);
  endtask : pulse

  function automatic logic irq_exp(input logic [7:0] c, input logic [7:0] e, input logic [7:0] f);
    return c[7] & ((c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0]) | (c[6] & |(e & f)));
  endfunction : irq_exp

  initial begin
    t = 8'($urandom(32'h7e1d_c75d));
    repeat (3) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    chk_reg(ctl, 8'h00);
    chk_reg(pie, 8'h00);
    chk_err(1'b0);
    chk_reg(8'h14, 8'h00);
    chk_err(1'b1);
    t = 8'($urandom);
    apb(1'b1, pie, t);
    chk_reg(pie, t);
    PSTRB <= 4'hE;
    apb(1'b1, pie, ~t);
    PSTRB <= 4'hF;
    chk_reg(pie, t);
    apb(1'b1, pie, 8'h00);
    // Timer rollover from a random start near the top
    t = 8'hFF - 8'($urandom % 4);
    apb(1'b1, irq_pkg::ADDR_TIMER_COUNT, t);
    while (t != 8'hFF) begin
      pulse(4'h8);
      t++;
    end
    chk_reg(ctl, 8'h00);
    pulse(4'h8);
    chk_reg(ctl, 8'h04);
    apb(1'b1, ctl, 8'hA4);
    chk_irq(irq_exp(8'hA4, 8'h00, 8'h00));
    apb(1'b1, ctl, 8'h84);
    chk_irq(irq_exp(8'h84, 8'h00, 8'h00));
    apb(1'b1, ctl, 8'h00);
    chk_reg(ctl, 8'h00);
    EXTERNAL_IRQ_PIN <= 1'b1;
    repeat (10) @(posedge CLOCK);
    chk_reg(ctl, 8'h02);
    apb(1'b1, ctl, 8'h92);
    chk_irq(irq_exp(8'h92, 8'h00, 8'h00));
    apb(1'b1, ctl, 8'h00);
    // Falling edge mode
    EXT_EDGE_RISING <= 1'b0;
    EXTERNAL_IRQ_PIN <= 1'b0;
    repeat (10) @(posedge CLOCK);
    chk_reg(ctl, 8'h02);
    apb(1'b1, ctl, 8'h00);
    // Port change on a random enabled pin, neighbour first
    p = $urandom % 6;
    apb(1'b1, irq_pkg::ADDR_PER_PIN_CHANGE_EN, 8'(1 << p));
    FIRST_GPIO_PORT <= 6'(1 << ((p + 1) % 6));
    repeat (10) @(posedge CLOCK);
    chk_reg(ctl, 8'h00);
    FIRST_GPIO_PORT <= FIRST_GPIO_PORT | 6'(1 << p);
    repeat (10) @(posedge CLOCK);
    chk_reg(ctl, 8'h01);
    apb(1'b1, ctl, 8'h89);
    chk_irq(irq_exp(8'h89, 8'h00, 8'h00));
    apb(1'b1, ctl, 8'h81);
    chk_irq(irq_exp(8'h81, 8'h00, 8'h00));
    for (int i = 0; i < 8; i++) begin
      t = 8'h01 << i;
      pulse(4'(i));
      chk_reg(pfl, t);
      apb(1'b1, pie, t);
      apb(1'b1, ctl, 8'h40);
      chk_irq(irq_exp(8'h40, t, t));
      apb(1'b1, ctl, 8'hC0);
      chk_irq(irq_exp(8'hC0, t, t));
      apb(1'b1, pie, ~t);
      chk_irq(irq_exp(8'hC0, ~t, t));
      apb(1'b1, pie, 8'hFF);
      apb(1'b1, ctl, 8'h80);
      chk_irq(irq_exp(8'h80, 8'hFF, t));
      apb(1'b1, pfl, 8'h00);
      chk_reg(pfl, (i == 5 || i == 1) ? t : 8'h00);
      if (i == 5) pulse(4'h9);
      if (i == 1) pulse(4'hA);
      chk_reg(pfl, 8'h00);
    end
    // Mid-run reset keeps the timer count
    apb(1'b1, irq_pkg::ADDR_TIMER_COUNT, 8'h5A);
    apb(1'b1, pfl, 8'h00);
    apb(1'b1, ctl, 8'hF8);
    chk_irq(irq_exp(8'hF8, 8'hFF, 8'h00));
    SYS_RST <= 1'b1;
    @(posedge CLOCK);
    SYS_RST <= 1'b0;
    chk_reg(ctl, 8'h00);
    chk_reg(pie, 8'h00);
    chk_reg(irq_pkg::ADDR_TIMER_COUNT, 8'h5A);
    conclude();
  end
endmodule : tb_core_interrupt_enable_flag_logic
